// [common/cor_pkg.sv]
// Shared constants and types for the charger option control register bank.
package cor_pkg;

	// Command codes of the words that this block holds or watches.
	localparam logic [7:0] CMD_OPT_A = 8'h12;
	localparam logic [7:0] CMD_OPT_B = 8'h3B;
	localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
	localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;

	// Reset values and writable masks of the two option words.
	localparam logic [15:0] OPT_A_RESET = 16'hE108;
	localparam logic [15:0] OPT_A_WMASK = 16'hE339;
	localparam logic [15:0] OPT_B_RESET = 16'hC210;
	localparam logic [15:0] OPT_B_WMASK = 16'hFEFA;

	// Field positions of the first option word.
	localparam int A_LOW_POWER = 15;
	localparam int A_WD_HI = 14;
	localparam int A_WD_LO = 13;
	localparam int A_RATE_HI = 9;
	localparam int A_RATE_LO = 8;
	localparam int A_LEARN = 5;
	localparam int A_ADP_GAIN = 4;
	localparam int A_DIS_GAIN = 3;
	localparam int A_CHG_BLOCK = 0;

	localparam logic [1:0] RATE_RESERVED = 2'h3;
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_SHORT = 2'h1;
	localparam logic [1:0] WD_MEDIUM = 2'h2;

	// Watchdog periods in seconds.
	localparam logic [7:0] WD_SHORT_SEC = 8'd5;
	localparam logic [7:0] WD_MEDIUM_SEC = 8'd88;
	localparam logic [7:0] WD_LONG_SEC = 8'd175;

	// Clock period and the derived cycles per second.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEC_NS = 1_000_000_000;
	localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;

	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h09;

	// Layout of the second option word.
	typedef struct packed {
		logic [1:0] depletion_threshold;
		logic [1:0] sense_resistor_ratio;
		logic discharge_monitor_output_enable;
		logic power_monitor_output_enable;
		logic power_monitor_gain;
		logic rsvd8;
		logic comparator_reference;
		logic comparator_polarity;
		logic [1:0] comparator_deglitch;
		logic latch_off_enable;
		logic rsvd2;
		logic shipping_discharge_enable;
		logic rsvd0;
	} cor_opt_b_s;

	// Status levels from the analog side.
	typedef struct packed {
		logic battery_only;
		logic battery_absent_input;
		logic battery_depleted;
	} cor_stat_s;

	// Control levels to the converter, monitors and switches.
	typedef struct packed {
		logic [1:0] converter_rate_select;
		logic adapter_sense_gain;
		logic discharge_sense_gain;
		logic low_power_active;
		logic processor_hot_alert_enable;
		logic discharge_monitor_enable;
		logic power_monitor_enable;
		logic comparator_enable;
		logic converter_enable;
		logic charge_enable;
		logic learn_active;
		logic adapter_input_switch_on;
		logic reverse_blocking_switch_on;
		logic battery_path_switch_on;
		logic watchdog_expired;
	} cor_ctl_s;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD, ST_WLO, ST_ACK_WLO,
		ST_WHI, ST_ACK_WHI, ST_RLO, ST_RACK_LO, ST_RHI, ST_RACK_HI
	} cor_state_e;

endpackage

// [verilog/cor_option_regs.sv]
// SMBus word slave holding the two charger option words and the write watchdog.
`timescale 1ns/10ps

module cor_option_regs #(
	parameter logic [6:0] SMB_ADDR = cor_pkg::SMB_ADDR_DEFAULT,
	parameter int unsigned CYCLES_PER_SEC = cor_pkg::CYC_PER_SEC
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_smb_scl,
	input wire logic i_smb_sda,
	output logic o_smb_sda,
	output logic o_smb_sda_oe_n,
	input cor_pkg::cor_stat_s i_stat,
	output cor_pkg::cor_ctl_s o_ctl,
	output cor_pkg::cor_opt_b_s o_opt_b
);
	import cor_pkg::*;

	typedef struct packed {
		cor_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [7:0] lo;
		logic [15:0] rdw;
		logic rd;
		logic nack;
		logic drive;
		logic scl;
		logic sda;
		logic [15:0] opt_a;
		logic [15:0] opt_b;
		logic [31:0] pre;
		logic [7:0] secs;
		logic expired;
		cor_ctl_s ctl;
	} cor_regs_s;

	cor_regs_s s_q;
	cor_regs_s s_d;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic setting_write;
	logic low_power;
	logic learn_on;
	logic [15:0] wword;
	cor_opt_b_s b_view;

	// Word returned for a read command; commands held elsewhere read as zero.
	function automatic logic [15:0] read_word(input logic [7:0] c, input logic [15:0] a,
			input logic [15:0] b);
		logic [15:0] r;
		r = 16'h0000;
		if (c == CMD_OPT_A) begin
			r = a & OPT_A_WMASK;
		end else if (c == CMD_OPT_B) begin
			r = b & OPT_B_WMASK;
		end
		return r;
	endfunction

	// Merge a written word into an old one, leaving read-only bits alone.
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
			input logic [15:0] mask);
		return (old & ~mask) | (nw & mask);
	endfunction

	// Watchdog period in seconds for a select code.
	function automatic logic [7:0] wd_limit(input logic [1:0] sel);
		logic [7:0] r;
		r = WD_LONG_SEC;
		if (sel == WD_SHORT) begin
			r = WD_SHORT_SEC;
		end else if (sel == WD_MEDIUM) begin
			r = WD_MEDIUM_SEC;
		end
		return r;
	endfunction

	// Watchdog select code of the first option word.
	function automatic logic [1:0] wd_select(input logic [15:0] a);
		return a[A_WD_HI:A_WD_LO];
	endfunction

	// START and STOP need SCL high in both samples, so a data change at a clock edge is not taken.
	assign scl_rise = i_smb_scl & ~s_q.scl;
	assign scl_fall = ~i_smb_scl & s_q.scl;
	assign bus_start = i_smb_scl & s_q.scl & s_q.sda & ~i_smb_sda;
	assign bus_stop = i_smb_scl & s_q.scl & ~s_q.sda & i_smb_sda;
	assign wword = {s_q.sh, s_q.lo};
	assign b_view = cor_opt_b_s'(s_q.opt_b);

	always_comb begin
		s_d = s_q;
		setting_write = 1'b0;
		s_d.scl = i_smb_scl;
		s_d.sda = i_smb_sda;
		if (bus_start) begin
			s_d.st = ST_ADDR;
			s_d.cnt = 4'h0;
			s_d.drive = 1'b0;
		end else if (bus_stop) begin
			s_d.st = ST_IDLE;
			s_d.drive = 1'b0;
		end else if (scl_rise) begin
			unique case (s_q.st)
				ST_ADDR, ST_CMD, ST_WLO, ST_WHI: begin
					s_d.sh = {s_q.sh[6:0], i_smb_sda};
					s_d.cnt = s_q.cnt + 4'h1;
				end
				ST_RLO, ST_RHI: begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
				ST_RACK_LO, ST_RACK_HI: begin
					s_d.nack = i_smb_sda;
				end
				ST_IDLE, ST_ACK_ADDR, ST_ACK_CMD, ST_ACK_WLO, ST_ACK_WHI: begin
				end
				// An illegal state code drops back to idle and lets go of the data line.
				default: begin
					s_d.st = ST_IDLE;
					s_d.drive = 1'b0;
				end
			endcase
		end else if (scl_fall) begin
			unique case (s_q.st)
				ST_IDLE: begin
				end
				ST_ADDR: begin
					if (s_q.cnt == BYTE_BITS) begin
						s_d.cnt = 4'h0;
						if (s_q.sh[7:1] == SMB_ADDR) begin
							s_d.rd = s_q.sh[0];
							s_d.drive = 1'b1;
							s_d.st = ST_ACK_ADDR;
						end else begin
							s_d.st = ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (s_q.rd) begin
						s_d.rdw = read_word(s_q.cmd, s_q.opt_a, s_q.opt_b);
						s_d.sh = s_d.rdw[7:0];
						s_d.drive = ~s_d.rdw[7];
						s_d.st = ST_RLO;
					end else begin
						s_d.drive = 1'b0;
						s_d.st = ST_CMD;
					end
				end
				ST_CMD, ST_WLO, ST_WHI: begin
					if (s_q.cnt == BYTE_BITS) begin
						s_d.cnt = 4'h0;
						s_d.drive = 1'b1;
						if (s_q.st == ST_CMD) begin
							s_d.cmd = s_q.sh;
							s_d.st = ST_ACK_CMD;
						end else if (s_q.st == ST_WLO) begin
							s_d.lo = s_q.sh;
							s_d.st = ST_ACK_WLO;
						end else begin
							// A word is stored only once its high byte is in; a cut frame stores nothing.
							s_d.st = ST_ACK_WHI;
							if (s_q.cmd == CMD_OPT_A) begin
								s_d.opt_a = merge(s_q.opt_a, wword, OPT_A_WMASK);
								if (wword[A_RATE_HI:A_RATE_LO] == RATE_RESERVED) begin
									s_d.opt_a[A_RATE_HI:A_RATE_LO] =
										s_q.opt_a[A_RATE_HI:A_RATE_LO];
								end
							end else if (s_q.cmd == CMD_OPT_B) begin
								s_d.opt_b = merge(s_q.opt_b, wword, OPT_B_WMASK);
							end
							setting_write = (s_q.cmd == CMD_CHG_CURRENT) ||
								(s_q.cmd == CMD_CHG_VOLTAGE);
						end
					end
				end
				ST_ACK_CMD: begin
					s_d.drive = 1'b0;
					s_d.st = ST_WLO;
				end
				ST_ACK_WLO: begin
					s_d.drive = 1'b0;
					s_d.st = ST_WHI;
				end
				ST_ACK_WHI, ST_RACK_HI: begin
					s_d.drive = 1'b0;
					s_d.st = ST_IDLE;
				end
				ST_RLO, ST_RHI: begin
					if (s_q.cnt == BYTE_BITS) begin
						s_d.cnt = 4'h0;
						s_d.drive = 1'b0;
						s_d.st = (s_q.st == ST_RLO) ? ST_RACK_LO : ST_RACK_HI;
					end else begin
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.drive = ~s_q.sh[6];
					end
				end
				ST_RACK_LO: begin
					if (!s_q.nack) begin
						s_d.sh = s_q.rdw[15:8];
						s_d.drive = ~s_q.rdw[15];
						s_d.st = ST_RHI;
					end else begin
						s_d.st = ST_IDLE;
					end
				end
				// An illegal state code drops back to idle and lets go of the data line.
				default: begin
					s_d.st = ST_IDLE;
					s_d.drive = 1'b0;
				end
			endcase
		end

		// A pulled battery ends learn mode; this level outranks a host write of the bit.
		if (i_stat.battery_absent_input) begin
			s_d.opt_a[A_LEARN] = 1'b0;
		end

		// Watchdog: a prescaler makes one-second ticks so the seconds count stays small.
		if (wd_select(s_q.opt_a) == WD_OFF || setting_write) begin
			s_d.pre = 32'h0000_0000;
			s_d.secs = 8'h00;
			s_d.expired = 1'b0;
		end else if (!s_q.expired) begin
			s_d.pre = s_q.pre + 32'h0000_0001;
			if (s_q.pre >= CYCLES_PER_SEC - 1) begin
				s_d.pre = 32'h0000_0000;
				s_d.secs = s_q.secs + 8'h01;
				if (s_q.secs + 8'h01 >= wd_limit(wd_select(s_q.opt_a))) begin
					s_d.expired = 1'b1;
				end
			end
		end

		s_d.ctl.converter_rate_select = s_q.opt_a[A_RATE_HI:A_RATE_LO];
		s_d.ctl.adapter_sense_gain = s_q.opt_a[A_ADP_GAIN];
		s_d.ctl.discharge_sense_gain = s_q.opt_a[A_DIS_GAIN];
		s_d.ctl.low_power_active = low_power;
		s_d.ctl.processor_hot_alert_enable = ~low_power;
		s_d.ctl.discharge_monitor_enable = b_view.discharge_monitor_output_enable &
			~low_power;
		s_d.ctl.power_monitor_enable = b_view.power_monitor_output_enable & ~low_power;
		s_d.ctl.comparator_enable = (b_view.comparator_deglitch != 2'h0) & ~low_power;
		s_d.ctl.converter_enable = ~s_q.expired;
		s_d.ctl.charge_enable = ~s_q.opt_a[A_CHG_BLOCK] & ~s_q.expired & ~learn_on;
		s_d.ctl.learn_active = learn_on;
		s_d.ctl.adapter_input_switch_on = ~learn_on;
		s_d.ctl.reverse_blocking_switch_on = ~learn_on;
		s_d.ctl.battery_path_switch_on = learn_on;
		s_d.ctl.watchdog_expired = s_q.expired;
	end

	assign low_power = i_stat.battery_only & s_q.opt_a[A_LOW_POWER];
	assign learn_on = s_q.opt_a[A_LEARN] & ~i_stat.battery_depleted &
		~i_stat.battery_absent_input;

	// Control outputs read zero in reset and take their decoded values one edge after release.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.scl <= 1'b1;
			s_q.sda <= 1'b1;
			s_q.nack <= 1'b1;
			s_q.opt_a <= OPT_A_RESET;
			s_q.opt_b <= OPT_B_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_smb_sda = 1'b0;
	assign o_smb_sda_oe_n = ~s_q.drive;
	assign o_ctl = s_q.ctl;
	assign o_opt_b = cor_opt_b_s'(s_q.opt_b & OPT_B_WMASK);

endmodule // cor_option_regs

// [sim/cor_option_regs_monitor.sv]
// Port assertions for the option register bank.
`timescale 1ns/10ps
module cor_option_regs_monitor (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_smb_scl,
	input wire logic i_smb_sda,
	input wire logic o_smb_sda,
	input wire logic o_smb_sda_oe_n,
	input cor_pkg::cor_stat_s i_stat,
	input cor_pkg::cor_ctl_s o_ctl,
	input cor_pkg::cor_opt_b_s o_opt_b
);
	import cor_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_learn;
		o_ctl.learn_active;
	endsequence
	lowpwr_src_a: assert property (!$past(i_stat.battery_only) |-> !o_ctl.low_power_active)
		else $error("low power without battery only");
	lowpwr_off_a: assert property (o_ctl.low_power_active |-> !(o_ctl.processor_hot_alert_enable
		| o_ctl.discharge_monitor_enable | o_ctl.power_monitor_enable | o_ctl.comparator_enable))
		else $error("monitor left on in low power");
	learn_sw_a: assert property (s_learn |-> !o_ctl.adapter_input_switch_on
		&& !o_ctl.reverse_blocking_switch_on && o_ctl.battery_path_switch_on)
		else $error("switch state wrong in learn");
	learn_abs_a: assert property ($past(i_stat.battery_absent_input) |-> !o_ctl.learn_active)
		else $error("learn kept with battery absent");
	learn_depl_a: assert property ($past(i_stat.battery_depleted) |-> !o_ctl.learn_active)
		else $error("learn entered while depleted");
	// Control outputs read zero in reset, so the first edge after release is skipped.
	wd_conv_a: assert property ($past(i_rst_n) |-> o_ctl.converter_enable == !o_ctl.watchdog_expired)
		else $error("converter enable disagrees with expiry");
	chg_block_a: assert property ((o_ctl.watchdog_expired || o_ctl.learn_active) |-> !o_ctl.charge_enable)
		else $error("charging allowed while blocked");
	rate_rsvd_a: assert property (o_ctl.converter_rate_select != RATE_RESERVED)
		else $error("reserved rate code applied");
	optb_rsvd_a: assert property ({o_opt_b.rsvd8, o_opt_b.rsvd2, o_opt_b.rsvd0} == 3'h0)
		else $error("reserved bit set in second word");
endmodule // cor_option_regs_monitor
bind cor_option_regs cor_option_regs_monitor u_mon (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_smb_scl(i_smb_scl), .i_smb_sda(i_smb_sda), .o_smb_sda(o_smb_sda),
	.o_smb_sda_oe_n(o_smb_sda_oe_n), .i_stat(i_stat), .o_ctl(o_ctl), .o_opt_b(o_opt_b));

// [sim/cor_smb_host.sv]
// Behavioural host controller issuing word reads and writes on the two-wire bus.
`timescale 1ns/10ps
module cor_smb_host #(
	parameter logic [6:0] ADDR = cor_pkg::SMB_ADDR_DEFAULT
) (
	input wire logic i_core_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	import cor_pkg::*;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Four cycles per phase keeps each bus phase well above the two-cycle minimum.
	task automatic hb();
		repeat (4) @(posedge i_core_clk);
		#1;
	endtask
	task automatic bitx(input logic b, output logic r);
		o_sda = b;
		hb();
		o_scl = 1'b1;
		hb();
		r = i_sda;
		o_scl = 1'b0;
		hb();
	endtask
	task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(m, a);
	endtask
	task automatic start();
		o_sda = 1'b1;
		hb();
		o_scl = 1'b1;
		hb();
		o_sda = 1'b0;
		hb();
		o_scl = 1'b0;
		hb();
	endtask
	task automatic stop();
		o_sda = 1'b0;
		hb();
		o_scl = 1'b1;
		hb();
		o_sda = 1'b1;
		hb();
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
		logic [7:0] q;
		logic a;
		start();
		xb({ADDR, 1'b0}, 1'b1, q, a);
		xb(cmd, 1'b1, q, a);
		xb(w[7:0], 1'b1, q, a);
		xb(w[15:8], 1'b1, q, a);
		stop();
	endtask
	task automatic rd(input logic [7:0] cmd, output logic [15:0] w);
		logic [7:0] q;
		logic a;
		start();
		xb({ADDR, 1'b0}, 1'b1, q, a);
		xb(cmd, 1'b1, q, a);
		start();
		xb({ADDR, 1'b1}, 1'b1, q, a);
		xb(8'hFF, 1'b0, w[7:0], a);
		xb(8'hFF, 1'b1, w[15:8], a);
		stop();
	endtask
endmodule // cor_smb_host

// [sim/cor_option_regs_tb_top.sv]
// Self-checking bench for the option register bank.
`timescale 1ns/10ps
module cor_option_regs_tb_top;
	import cor_pkg::*;
	localparam int CPS = 10;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic scl;
	logic host_sda;
	logic sda_oe_n;
	logic sda_drv;
	cor_stat_s stat = 3'h4;
	cor_ctl_s ctl;
	cor_opt_b_s optb;
	// The bus line has a pull-up, so a released line reads high.
	wire logic sda = host_sda & (sda_oe_n | sda_drv);
	int num_errors = 0;
	int checked = 0;
	always #5 i_core_clk = ~i_core_clk;
	cor_smb_host host (.i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
	cor_option_regs #(.CYCLES_PER_SEC(CPS)) uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_smb_scl(scl), .i_smb_sda(sda), .o_smb_sda(sda_drv), .o_smb_sda_oe_n(sda_oe_n),
		.i_stat(stat), .o_ctl(ctl), .o_opt_b(optb));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic t_reset();
		logic [15:0] w;
		host.rd(CMD_OPT_A, w);
		cmp(w, OPT_A_RESET);
		host.rd(CMD_OPT_B, w);
		cmp(w, OPT_B_RESET);
		cmp({ctl.converter_rate_select, ctl.adapter_sense_gain, ctl.discharge_sense_gain}, 16'h0005);
		cmp({ctl.low_power_active, ctl.processor_hot_alert_enable}, 16'h0002);
		stat.battery_only = 1'b0;
		cyc(2);
		cmp({ctl.low_power_active, ctl.processor_hot_alert_enable}, 16'h0001);
		stat.battery_only = 1'b1;
		cyc(2);
	endtask
	task automatic t_write_a();
		logic [15:0] w;
		host.wr(CMD_OPT_A, 16'hFFFF);
		host.rd(CMD_OPT_A, w);
		cmp(w, 16'hE139);
		cmp({ctl.learn_active, ctl.adapter_input_switch_on, ctl.reverse_blocking_switch_on,
			ctl.battery_path_switch_on, ctl.charge_enable}, 16'h0012);
		host.wr(CMD_OPT_A, 16'h0210);
		host.rd(CMD_OPT_A, w);
		cmp(w, 16'h0210);
		cmp({ctl.converter_rate_select, ctl.adapter_sense_gain, ctl.discharge_sense_gain,
			ctl.processor_hot_alert_enable, ctl.charge_enable}, 16'h002B);
		host.wr(CMD_OPT_A, 16'h0211);
		cmp(ctl.charge_enable, 16'h0000);
	endtask
	task automatic t_learn();
		logic [15:0] w;
		host.wr(CMD_OPT_A, 16'h0020);
		stat.battery_depleted = 1'b1;
		cyc(2);
		cmp(ctl.learn_active, 16'h0000);
		stat.battery_depleted = 1'b0;
		cyc(2);
		cmp(ctl.learn_active, 16'h0001);
		stat.battery_absent_input = 1'b1;
		cyc(2);
		stat.battery_absent_input = 1'b0;
		host.rd(CMD_OPT_A, w);
		cmp(w, 16'h0000);
	endtask
	task automatic t_optb();
		logic [15:0] w;
		host.wr(CMD_OPT_B, 16'hFFFF);
		host.rd(CMD_OPT_B, w);
		cmp(w, 16'hFEFA);
		cmp(optb, 16'hFEFA);
		cmp({ctl.discharge_monitor_enable, ctl.power_monitor_enable, ctl.comparator_enable}, 16'h0007);
	endtask
	task automatic t_wd();
		int secs[3] = '{5, 88, 175};
		for (int s = 1; s < 4; s++) begin
			host.wr(CMD_OPT_A, {1'b0, s[1:0], 13'h0000});
			host.wr(s[0] ? CMD_CHG_CURRENT : CMD_CHG_VOLTAGE, 16'h0000);
			cmp(ctl.converter_enable, 16'h0001);
			cyc(secs[s-1] * CPS - 40);
			cmp(ctl.watchdog_expired, 16'h0000);
			cyc(30);
			cmp(ctl.converter_enable, 16'h0000);
		end
		host.wr(CMD_OPT_A, 16'h0000);
		cmp(ctl.converter_enable, 16'h0001);
	endtask
	initial begin
		cyc(5);
		i_rst_n = 1'b1;
		cyc(2);
		t_reset();
		t_write_a();
		t_learn();
		t_optb();
		t_wd();
		give_verdict();
	end
	initial begin
		#400000;
		num_errors++;
		give_verdict();
	end
endmodule // cor_option_regs_tb_top
